// [pkg/spi_port_pkg.sv]
// constants shared by the serial peripheral port and its register bus
package spi_port_pkg;

  // register byte offsets
  localparam logic [11:0] OFF_STAT = 12'h000;
  localparam logic [11:0] OFF_RX = 12'h004;
  localparam logic [11:0] OFF_TX = 12'h008;
  localparam logic [11:0] OFF_DIV = 12'h00C;
  localparam logic [11:0] OFF_CTRL = 12'h010;
  localparam logic [11:0] OFF_MASK = 12'h014;

  // serial_port_control_reg fields
  localparam int CTL_EN = 0;
  localparam int CTL_MST = 1;
  localparam int CTL_CPOL = 2;
  localparam int CTL_CPHA = 3;
  localparam int CTL_PINS = 4;
  localparam int CTL_W = 5;

  // status and mask fields
  localparam int STS_DONE = 0;
  localparam int STS_OVR = 1;
  localparam int STS_BUSY = 2;
  localparam int STS_W = 2;

  // values after reset
  localparam logic [CTL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [STS_W-1:0] MASK_RST = 2'h0;
  localparam logic [7:0] TXD_RST = 8'h00;

  // serial word and timing
  localparam int WORD_BITS = 8;
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam int CLK_MHZ = 100;
  localparam int SCK_MAX_MBPS = 20;
  localparam int SLV_MAX_MBPS = 10;
  // smallest divider that keeps the master clock at or under its top rate
  localparam int DIV_MIN_I = (CLK_MHZ + 2 * SCK_MAX_MBPS - 1) / (2 * SCK_MAX_MBPS) - 1;
  localparam logic [7:0] DIV_MIN = DIV_MIN_I[7:0];

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MASTER = 2'b01,
    ST_SLAVE = 2'b10
  } port_state_e;

endpackage

// [hdl/spi_port.sv]
// byte-wide full-duplex serial peripheral port, master or slave, apb registers
`timescale 1ns/1ps
module spi_port (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // port 1 bit 4, serial clock
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  // port 1 bit 5, master in slave out
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  // port 1 bit 6, master out slave in
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  // port 1 bit 7, active-low select
  input wire logic sel_n_in,
  output logic sel_n_out,
  output logic sel_n_oe
);
  import spi_port_pkg::*;

  typedef struct packed {
    port_state_e st;
    logic [CTL_W-1:0] ctrl;
    logic [7:0] div;
    logic [STS_W-1:0] mask;
    logic [STS_W-1:0] stat;
    logic [STS_W-1:0] clr;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic [7:0] sh;
    logic [7:0] rxs;
    logic [7:0] cnt;
    logic [3:0] edges;
    logic [1:0] cap;
    logic [1:0] fin;
    logic sclk;
    logic sel_n;
    logic sclk_oe;
    logic mosi_oe;
    logic miso_oe;
    logic sel_oe;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] sck_s;
    logic [2:0] miso_s;
    logic [2:0] mosi_s;
    logic [2:0] sel_s;
    logic sck_f;
    logic miso_f;
    logic mosi_f;
    logic sel_f;
  } port_s;

  port_s r;
  port_s n;

  logic wr;
  logic rd_acc;
  logic go;
  logic edge_go;
  logic lead;
  logic din;
  logic samp;
  logic done;
  logic busy;
  logic [7:0] rxs_n;
  logic [31:0] rdata;
  logic mapped;

  // divider below the floor is raised so the master never exceeds its top rate
  function automatic logic [7:0] eff_div(input logic [7:0] d);
    eff_div = (d < DIV_MIN) ? DIV_MIN : d;
  endfunction

  // a change counts once the second and third stages agree
  function automatic logic flt(input logic [2:0] s, input logic f);
    flt = (s[1] == s[2]) ? s[2] : f;
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign go = r.ctrl[CTL_EN] && r.ctrl[CTL_PINS];
  assign busy = (r.st == ST_MASTER) || ((r.st == ST_SLAVE) && !r.sel_f);

  always_comb begin
    rdata = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      OFF_STAT: rdata = {29'h0000_0000, busy, r.stat};
      OFF_RX: rdata = {24'h00_0000, r.rxd};
      OFF_TX: rdata = 32'h0000_0000;
      OFF_DIV: rdata = {24'h00_0000, r.div};
      OFF_CTRL: rdata = {27'h000_0000, r.ctrl};
      OFF_MASK: rdata = {30'h0000_0000, r.mask};
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    n = r;
    edge_go = 1'b0;
    lead = 1'b0;
    din = 1'b0;
    samp = 1'b0;
    done = 1'b0;
    rxs_n = r.rxs;
    n.pready = 1'b1;

    // pin synchronisers, first stage read only by the second
    n.sck_s = {r.sck_s[1:0], sclk_in};
    n.miso_s = {r.miso_s[1:0], miso_in};
    n.mosi_s = {r.mosi_s[1:0], mosi_in};
    n.sel_s = {r.sel_s[1:0], sel_n_in};
    n.sck_f = flt(r.sck_s, r.sck_f);
    n.miso_f = flt(r.miso_s, r.miso_f);
    n.mosi_f = flt(r.mosi_s, r.mosi_f);
    n.sel_f = flt(r.sel_s, r.sel_f);

    // register writes take effect at the access edge
    if (wr) begin
      case (paddr)
        OFF_TX: n.txd = pwdata[7:0];
        OFF_DIV: n.div = pwdata[7:0];
        OFF_CTRL: n.ctrl = pwdata[CTL_W-1:0];
        OFF_MASK: n.mask = pwdata[STS_W-1:0];
        default: n.txd = r.txd;
      endcase
    end

    // read data is captured in the setup cycle; only what was shown is cleared
    if (psel && !penable) begin
      n.prdata = rdata;
      n.pslverr = !mapped;
      n.clr = (!pwrite && paddr == OFF_STAT) ? r.stat : '0;
    end
    if (rd_acc && paddr == OFF_STAT) begin
      n.stat = r.stat & ~r.clr;
    end

    case (r.st)
      ST_IDLE: begin
        n.sclk = r.ctrl[CTL_CPOL];
        n.sel_n = 1'b1;
        n.cnt = 8'h00;
        n.edges = 4'h0;
        if (go && r.ctrl[CTL_MST] && wr && paddr == OFF_TX) begin
          n.st = ST_MASTER;
          n.sh = pwdata[7:0];
          n.sel_n = 1'b0;
        end else if (go && !r.ctrl[CTL_MST]) begin
          n.st = ST_SLAVE;
          n.sh = r.txd;
        end
      end
      ST_MASTER: begin
        if (!go || !r.ctrl[CTL_MST]) begin
          // disabling mid-byte aborts; no flag, select released
          n.st = ST_IDLE;
          n.sel_n = 1'b1;
          n.sclk = r.ctrl[CTL_CPOL];
        end else if (r.cnt == eff_div(r.div)) begin
          n.cnt = 8'h00;
          edge_go = 1'b1;
          lead = (r.sclk == r.ctrl[CTL_CPOL]);
          n.sclk = !r.sclk;
        end else begin
          n.cnt = r.cnt + 8'h01;
        end
      end
      ST_SLAVE: begin
        if (!go || r.ctrl[CTL_MST]) begin
          n.st = ST_IDLE;
        end else if (r.sel_f) begin
          // deselected: restart the word and keep the latest byte ready
          n.edges = 4'h0;
          n.sh = r.txd;
        end else if (r.sck_s[1] == r.sck_s[2] && r.sck_s[2] != r.sck_f) begin
          edge_go = 1'b1;
          lead = (r.sck_s[2] != r.ctrl[CTL_CPOL]);
          din = r.mosi_f;
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // the miso filter lags four cycles behind the pin, so the master takes each
    // sample two cycles after its clock edge; still inside the bit at top rate
    n.cap = {r.cap[0], 1'b0};
    n.fin = {r.fin[0], 1'b0};
    if (r.cap[1]) begin
      rxs_n = {r.rxs[6:0], r.miso_f};
      n.rxs = rxs_n;
    end
    if (r.fin[1]) begin
      done = 1'b1;
      n.rxd = rxs_n;
    end

    // shared shift engine: sample on one edge, launch on the other
    if (edge_go) begin
      samp = lead ^ r.ctrl[CTL_CPHA];
      if (samp && r.st == ST_MASTER) begin
        n.cap[0] = 1'b1;
      end else if (samp) begin
        rxs_n = {r.rxs[6:0], din};
        n.rxs = rxs_n;
      end else if (r.edges != 4'h0) begin
        n.sh = {r.sh[6:0], 1'b0};
      end
      n.edges = r.edges + 4'h1;
      if (r.edges == LAST_EDGE) begin
        // sixteen edges, eight periods, make one byte
        n.sh = r.txd;
        if (r.st == ST_MASTER) begin
          n.st = ST_IDLE;
          n.sel_n = 1'b1;
          n.fin[0] = 1'b1;
        end else begin
          done = 1'b1;
          n.rxd = rxs_n;
        end
      end
    end

    // sticky events: a set in the clearing cycle wins
    if (done) begin
      n.stat[STS_DONE] = 1'b1;
      n.stat[STS_OVR] = n.stat[STS_OVR] | r.stat[STS_DONE];
    end
    n.irq = |(n.stat & n.mask);

    // pin directions follow the role; nothing is driven until pins are given over
    n.sclk_oe = n.ctrl[CTL_PINS] && n.ctrl[CTL_MST];
    n.mosi_oe = n.ctrl[CTL_PINS] && n.ctrl[CTL_MST];
    n.sel_oe = n.ctrl[CTL_PINS] && n.ctrl[CTL_MST];
    // slave only drives miso while selected, so shared miso lines do not clash
    n.miso_oe = n.ctrl[CTL_PINS] && !n.ctrl[CTL_MST] && n.st == ST_SLAVE
                && !r.sel_f;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.ctrl <= CTRL_RST;
      r.div <= DIV_RST;
      r.mask <= MASK_RST;
      r.txd <= TXD_RST;
      r.sel_n <= 1'b1;
      r.sck_s <= 3'h0;
      r.sel_s <= 3'h7;
      r.sel_f <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;
  assign sclk_out = r.sclk;
  assign sclk_oe = r.sclk_oe;
  assign miso_out = r.sh[7];
  assign miso_oe = r.miso_oe;
  assign mosi_out = r.sh[7];
  assign mosi_oe = r.mosi_oe;
  assign sel_n_out = r.sel_n;
  assign sel_n_oe = r.sel_oe;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence mst_start;
    r.st == ST_IDLE ##1 r.st == ST_MASTER;
  endsequence

  sequence tx_kick;
    wr && paddr == OFF_TX && r.st == ST_IDLE && go && r.ctrl[CTL_MST];
  endsequence

  max_rate_a: assert property (
    r.st == ST_MASTER && $changed(r.sclk) |=> $stable(r.sclk)[*2])
    else $error("master clock half period shorter than three cycles");

  div_rate_a: assert property (
    $changed(r.sclk) && $past(r.st) == ST_MASTER
      |-> $past(r.cnt) == eff_div($past(r.div)))
    else $error("master clock toggled off the divider count");

  miso_dir_a: assert property (
    r.ctrl[CTL_MST] |-> !r.miso_oe)
    else $error("miso driven while master");

  mosi_dir_a: assert property (
    !r.ctrl[CTL_MST] |-> !r.mosi_oe && !r.sel_oe)
    else $error("mosi or select driven while slave");

  sclk_dir_a: assert property (
    r.sclk_oe |-> r.ctrl[CTL_MST] && r.ctrl[CTL_PINS])
    else $error("serial clock driven outside master mode");

  msb_first_a: assert property (
    mst_start |-> mosi_out == r.txd[7] && !r.sel_n)
    else $error("first bit out is not the top bit");

  sel_frame_a: assert property (
    r.st != ST_MASTER |-> r.sel_n)
    else $error("select low outside a master transfer");

  byte_len_a: assert property (
    $past(r.st) == ST_MASTER && r.st == ST_IDLE && $past(go) && $past(r.ctrl[CTL_MST])
      |-> $past(r.edges) == LAST_EDGE && r.edges == 4'h0)
    else $error("master byte ended after other than sixteen edges");

  rx_flag_a: assert property (
    $changed(r.rxd) |-> r.stat[STS_DONE])
    else $error("receive byte landed without its flag");

  start_a: assert property (
    tx_kick |=> r.st == ST_MASTER ##1 r.st == ST_MASTER)
    else $error("transmit write did not start a transfer");

  slave_idle_a: assert property (
    r.st == ST_SLAVE && r.sel_f |=> r.edges == 4'h0)
    else $error("slave counted edges while deselected");

  pins_off_a: assert property (
    !r.ctrl[CTL_PINS] |-> !(r.sclk_oe || r.mosi_oe || r.miso_oe || r.sel_oe))
    else $error("pin driven without serial pin function");

endmodule

// [tb/spi_far_model.sv]
// far-side serial device: answers as slave, runs frames as master
`timescale 1ns/1ps
module spi_far_model (
  // clock
  input wire logic pclk,
  // resolved pin levels
  input wire logic sclk_pin,
  input wire logic mosi_pin,
  input wire logic miso_pin,
  input wire logic sel_pin,
  // far-side drive
  output logic m_act,
  output logic m_sclk,
  output logic m_mosi,
  output logic m_sel_n,
  output logic s_oe,
  output logic s_miso
);
  logic [7:0] reply = 8'h00;
  logic [7:0] got = 8'h00;
  logic [7:0] sh = 8'h00;
  // six cycles a half period keeps the clock under the slave ceiling
  int half = 6;
  initial begin
    m_act = 1'b0;
    m_sclk = 1'b0;
    m_mosi = 1'b0;
    m_sel_n = 1'b1;
    s_miso = 1'b0;
  end
  // answer only while the port selects us, never during our own frames
  assign s_oe = !sel_pin && !m_act;
  always @(negedge sel_pin) if (!m_act) begin
    sh = reply;
    s_miso = sh[7];
  end
  always @(posedge sclk_pin) if (!m_act && !sel_pin) got = {got[6:0], mosi_pin};
  always @(negedge sclk_pin) if (!m_act && !sel_pin) begin
    sh = sh << 1;
    s_miso = sh[7];
  end
  task automatic mxfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    @(posedge pclk);
    m_act <= 1'b1;
    m_sclk <= 1'b0;
    repeat (half) @(posedge pclk);
    m_sel_n <= 1'b0;
    m_mosi <= tx[15];
    for (int i = 0; i < 8 * n; i++) begin
      repeat (half - 1) @(posedge pclk);
      @(negedge pclk);
      rx = {rx[14:0], miso_pin};
      @(posedge pclk);
      m_sclk <= 1'b1;
      repeat (half) @(posedge pclk);
      m_sclk <= 1'b0;
      tx = tx << 1;
      m_mosi <= tx[15];
    end
    repeat (half) @(posedge pclk);
    m_sel_n <= 1'b1;
    repeat (half) @(posedge pclk);
    m_act <= 1'b0;
  endtask
endmodule

// [tb/tb.sv]
// self-checking bench for the serial peripheral port
`timescale 1ns/1ps
module tb;
  import spi_port_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sclk_out, sclk_oe, miso_out, miso_oe, mosi_out, mosi_oe, sel_n_out, sel_n_oe;
  logic m_act, m_sclk, m_mosi, m_sel_n, s_oe, s_miso;
  wire logic sclk_pin, mosi_pin, miso_pin, sel_pin;
  int num_errors = 0;
  int total_checks = 0;
  int cnt = 0;
  int half_seen = 0;
  int rises = 0;
  logic sclk_q = 1'b0;
  logic [15:0] srx;
  logic [7:0] tx;
  logic [7:0] divs [3] = '{8'h00, 8'h02, 8'h05};
  logic [11:0] offs [5] = '{OFF_STAT, OFF_TX, OFF_DIV, OFF_CTRL, OFF_MASK};
  // undriven port 1 lines sit at their pull-up level
  assign sclk_pin = sclk_oe ? sclk_out : m_act ? m_sclk : 1'b1;
  assign mosi_pin = mosi_oe ? mosi_out : m_act ? m_mosi : 1'b1;
  assign sel_pin = sel_n_oe ? sel_n_out : m_act ? m_sel_n : 1'b1;
  assign miso_pin = miso_oe ? miso_out : s_oe ? s_miso : 1'b1;
  spi_port i_spi_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .sclk_in(sclk_pin), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .miso_in(miso_pin), .miso_out(miso_out), .miso_oe(miso_oe),
    .mosi_in(mosi_pin), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .sel_n_in(sel_pin),
    .sel_n_out(sel_n_out), .sel_n_oe(sel_n_oe));
  spi_far_model i_far (.pclk(pclk), .sclk_pin(sclk_pin), .mosi_pin(mosi_pin),
    .miso_pin(miso_pin), .sel_pin(sel_pin), .m_act(m_act), .m_sclk(m_sclk),
    .m_mosi(m_mosi), .m_sel_n(m_sel_n), .s_oe(s_oe), .s_miso(s_miso));
  always #5 pclk = ~pclk;
  // serial clock monitor: last half period and rising edge count
  always @(posedge pclk) begin
    sclk_q <= sclk_pin;
    cnt <= (sclk_pin !== sclk_q) ? 1 : cnt + 1;
    if (sclk_pin !== sclk_q) half_seen <= cnt;
    if (sclk_pin === 1'b1 && sclk_q === 1'b0) rises <= rises + 1;
  end
  task automatic conclude();
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, exp_err});
  endtask
  task automatic wait_sel(input logic lvl);
    int n;
    for (n = 0; n < 5000 && sel_pin !== lvl; n++) @(negedge pclk);
    if (sel_pin !== lvl) begin
      num_errors++;
      conclude();
    end
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 5; i++) rd(offs[i], 32'h0000_0000, 1'b0);
    rd(12'h018, 32'h0000_0000, 1'b1);
    wr(OFF_CTRL, 32'h0000_0003);
    wr(OFF_TX, 32'h0000_0011);
    repeat (3) @(negedge pclk);
    chk({sclk_oe, mosi_oe, sel_n_oe}, 3'b000);
    wr(OFF_CTRL, 32'h0000_0013);
    for (int k = 0; k < 3; k++) begin
      tx = 8'hA5 + 8'(k);
      i_far.reply = 8'h3C ^ 8'(k);
      wr(OFF_DIV, {24'h0, divs[k]});
      rises <= 0;
      wr(OFF_TX, {24'h0, tx});
      wait_sel(1'b0);
      wait_sel(1'b1);
      repeat (4) @(negedge pclk);
      chk(32'(rises), 32'd8);
      chk(32'(half_seen), 32'((divs[k] < 2 ? 2 : divs[k]) + 1));
      chk({24'h0, i_far.got}, {24'h0, tx});
      chk({31'h0, irq}, 32'h0);
      rd(OFF_RX, {24'h0, 8'h3C ^ 8'(k)}, 1'b0);
      rd(OFF_STAT, 32'h0000_0001, 1'b0);
    end
    wr(OFF_MASK, 32'h0000_0003);
    repeat (2) begin
      wr(OFF_TX, 32'h0000_0081);
      wait_sel(1'b0);
      wait_sel(1'b1);
    end
    repeat (3) @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    rd(OFF_STAT, 32'h0000_0003, 1'b0);
    repeat (2) @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_CTRL, 32'h0000_0011);
    wr(OFF_TX, 32'h0000_005A);
    repeat (4) @(negedge pclk);
    chk({sclk_oe, mosi_oe, miso_oe, sel_n_oe}, 4'h0);
    i_far.mxfer(16'hC396, 2, srx);
    chk({16'h0, srx}, 32'h0000_5A5A);
    rd(OFF_RX, 32'h0000_0096, 1'b0);
    rd(OFF_STAT, 32'h0000_0003, 1'b0);
    conclude();
  end
endmodule
